// ==== common/afc_pkg.sv ====
// Constants, field layouts and carrier types for the acquisition format register pair.
// Assumes a classic Wishbone slave with 32-bit data and a single 20 MHz clock.
package afc_pkg;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam logic [3:0]  ADDR_FORMAT_CTRL = 4'h0;
	localparam logic [3:0]  ADDR_LANE_DIAG   = 4'h4;
	localparam logic [3:0]  ADDR_LINE_MULT   = 4'h8;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int WIN_LSB  = 0;
	localparam int WIN_W    = 17;
	localparam int FMT_LSB  = 17;
	localparam int FMT_W    = 5;
	localparam int SRC_LSB  = 22;
	localparam int SRC_W    = 4;
	localparam int DEP_LSB  = 26;
	localparam int DEP_W    = 5;
	localparam int FORCE_BIT = 31;
	localparam int LANE_A_LSB = 0;
	localparam int ADDR_W   = 15;
	localparam int WP_BIT   = 15;
	localparam int LANE_B_LSB = 16;
	localparam int OWNER_BIT = 31;
	localparam int MULT_W   = 2;

	// ********************************************************************
	// Reset values and codes
	// ********************************************************************
	localparam logic [16:0] WIN_RST   = 17'h00000;
	localparam logic [3:0]  SRC_RST   = 4'h0;
	localparam logic [4:0]  DEP_RST   = 5'h00;
	localparam logic [1:0]  MULT_X1   = 2'h0;
	localparam logic [1:0]  MULT_X2   = 2'h1;
	localparam logic [3:0]  SRC_CAM      = 4'h0;
	localparam logic [3:0]  SRC_CAM_NOVAL = 4'h1;
	localparam logic [3:0]  SRC_HWEDGE   = 4'h3;
	localparam logic [3:0]  SRC_DWEDGE   = 4'h4;
	localparam logic [3:0]  SRC_K00      = 4'h5;
	localparam logic [3:0]  SRC_KFF      = 4'h6;
	localparam logic [3:0]  SRC_KAA      = 4'h7;
	localparam logic [3:0]  SRC_K55      = 4'h8;
	localparam logic [3:0]  SRC_SEQ      = 4'h9;
	localparam logic [3:0]  SRC_VWEDGE   = 4'ha;
	localparam logic [63:0] SEQ_BYTES    = 64'habcdef0123456789;
	localparam int          TAPS         = 8;

	// Packing class of the pixel depth code.
	typedef enum logic [2:0] {
		PK_MONO, PK_C32, PK_C24, PK_C10_32, PK_C12_48, PK_RSVD
	} afc_pack_type;

	// Pixel word from the camera or pattern source, one byte per tap.
	typedef struct packed {
		logic        valid;
		logic [63:0] taps;
	} afc_video_type;

	// Decoded acquisition settings.
	typedef struct packed {
		logic [17:0]  window_clocks;
		logic [4:0]   pix_bits;
		afc_pack_type pack;
		logic         bayer;
		logic         dual_cam;
		logic         fmt_valid;
	} afc_mode_type;

endpackage

// ==== logic/afc_regs.sv ====
// Acquisition format control and lane diagnostic registers with test pattern source.
// Assumes the camera stream and the buffer write strobes are synchronous to clk_i.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
module afc_regs #(
	parameter logic [4:0] FORMAT_CODE = 5'h00 // Format of the built-in firmware image.
) (
	input  wire logic                  clk_i,     // 20 MHz system clock.
	input  wire logic                  nrst_i,    // Asynchronous reset, active low.
	input  wire logic                  wb_cyc_i,  // Wishbone cycle.
	input  wire logic                  wb_stb_i,  // Wishbone strobe.
	input  wire logic                  wb_we_i,   // Wishbone write enable.
	input  wire logic [3:0]            wb_adr_i,  // Byte address.
	input  wire logic [3:0]            wb_sel_i,  // Byte lane selects.
	input  wire logic [31:0]           wb_dat_i,  // Write data.
	output logic      [31:0]           wb_dat_o,  // Read data.
	output logic                       wb_ack_o,  // Acknowledge.
	input  wire afc_pkg::afc_video_type cam_i,    // Camera taps and valid qualifier.
	input  wire logic                  line_i,    // Line enable from the camera.
	input  wire logic                  frame_i,   // Frame start pulse.
	input  wire logic                  lane_a_we_i, // Lane A buffer write request.
	input  wire logic [14:0]           lane_a_addr_i, // Lane A buffer address.
	input  wire logic                  lane_b_we_i, // Lane B buffer write request.
	input  wire logic [14:0]           lane_b_addr_i, // Lane B buffer address.
	output afc_pkg::afc_video_type     video_o,   // Selected and masked video.
	output logic                       haw_o,     // Horizontal active window.
	output logic                       lane_a_we_o, // Gated lane A buffer write.
	output logic                       lane_b_we_o, // Gated lane B buffer write.
	output afc_pkg::afc_mode_type      mode_o,    // Decoded acquisition mode.
	output logic                       uart_own_o // Serial port owned by this grabber.
);

	// ********************************************************************
	// Register state
	// ********************************************************************
	logic [16:0] clocks_q;
	logic [3:0]  src_q;
	logic [4:0]  dep_q;
	logic        force_q;
	logic        wp_q;
	logic        own_q;
	logic [1:0]  mult_q;
	logic [14:0] last_a_q;
	logic [14:0] last_b_q;
	logic [17:0] hcnt_q;
	logic [7:0]  wedge_q;
	logic [7:0]  phase_q;
	logic        line_q;
	logic        req;
	logic        wr;
	logic [31:0] rd_d;
	logic [17:0] window;
	afc_pkg::afc_video_type vid_d;
	afc_pkg::afc_mode_type  mode_d;
	logic [4:0]  full_bits;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr  = req & wb_we_i;

	// ********************************************************************
	// Wishbone slave
	// ********************************************************************

	// One wait state: ack rises the edge after the request and drops next.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_d : 32'h00000000;
		end
	end

	// Read mux; unmapped addresses read zero and still acknowledge.
	always_comb begin
		rd_d = 32'h00000000;
		if (wb_adr_i == afc_pkg::ADDR_FORMAT_CTRL) begin
			rd_d[afc_pkg::WIN_LSB +: afc_pkg::WIN_W]   = clocks_q;
			rd_d[afc_pkg::FMT_LSB +: afc_pkg::FMT_W]   = FORMAT_CODE;
			rd_d[afc_pkg::SRC_LSB +: afc_pkg::SRC_W]   = src_q;
			rd_d[afc_pkg::DEP_LSB +: afc_pkg::DEP_W]   = dep_q;
			rd_d[afc_pkg::FORCE_BIT]                   = force_q;
		end else if (wb_adr_i == afc_pkg::ADDR_LANE_DIAG) begin
			rd_d[afc_pkg::LANE_A_LSB +: afc_pkg::ADDR_W] = last_a_q;
			rd_d[afc_pkg::WP_BIT]                        = wp_q;
			rd_d[afc_pkg::LANE_B_LSB +: afc_pkg::ADDR_W] = last_b_q;
			rd_d[afc_pkg::OWNER_BIT]                     = own_q;
		end else if (wb_adr_i == afc_pkg::ADDR_LINE_MULT) begin
			rd_d[afc_pkg::MULT_W-1:0] = mult_q;
		end
	end

	// Format control writes, per byte lane; the format field is read-only.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clocks_q <= afc_pkg::WIN_RST;
			src_q   <= afc_pkg::SRC_RST;
			dep_q   <= afc_pkg::DEP_RST;
			force_q <= 1'b0;
		end else if (wr && wb_adr_i == afc_pkg::ADDR_FORMAT_CTRL) begin
			if (wb_sel_i[0]) clocks_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1]) clocks_q[15:8] <= wb_dat_i[15:8];
			if (wb_sel_i[2]) begin
				clocks_q[16] <= wb_dat_i[16];
				src_q[1:0]  <= wb_dat_i[23:22];
			end
			if (wb_sel_i[3]) begin
				src_q[3:2] <= wb_dat_i[25:24];
				dep_q      <= wb_dat_i[30:26];
				force_q    <= wb_dat_i[31];
			end
		end
	end

	// Lane diagnostic register: protect bit and serial port ownership.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp_q  <= 1'b0;
			own_q <= 1'b0;
		end else if (wr && wb_adr_i == afc_pkg::ADDR_LANE_DIAG) begin
			if (wb_sel_i[1]) wp_q <= wb_dat_i[afc_pkg::WP_BIT];
			if (wb_sel_i[3]) own_q <= wb_dat_i[afc_pkg::OWNER_BIT];
		end
	end

	// Line length multiplier.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mult_q <= afc_pkg::MULT_X1;
		end else if (wr && wb_adr_i == afc_pkg::ADDR_LINE_MULT && wb_sel_i[0]) begin
			mult_q <= wb_dat_i[afc_pkg::MULT_W-1:0];
		end
	end

	// ********************************************************************
	// Buffer write gating and last address capture
	// ********************************************************************

	// Addresses are captured only for writes that really reach the buffer.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lane_a_we_o <= 1'b0;
			lane_b_we_o <= 1'b0;
			last_a_q    <= 15'h0000;
			last_b_q    <= 15'h0000;
		end else begin
			lane_a_we_o <= lane_a_we_i & ~wp_q;
			lane_b_we_o <= lane_b_we_i & ~wp_q;
			if (lane_a_we_i && !wp_q) last_a_q <= lane_a_addr_i;
			if (lane_b_we_i && !wp_q) last_b_q <= lane_b_addr_i;
		end
	end

	// ********************************************************************
	// Horizontal active window
	// ********************************************************************

	// Reserved multiplier codes fall back to the unscaled count.
	assign window = (mult_q == afc_pkg::MULT_X2) ? {clocks_q, 1'b0} : {1'b0, clocks_q};

	// Counts clocks, not pixels, so multi-tap cameras fill it faster.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			line_q <= 1'b0;
			hcnt_q <= 18'h00000;
			haw_o  <= 1'b0;
		end else begin
			line_q <= line_i;
			if (line_i && !line_q) begin
				hcnt_q <= 18'h00000;
				haw_o  <= (window != 18'h00000);
			end else if (haw_o) begin
				hcnt_q <= hcnt_q + 18'h00001;
				if (hcnt_q + 18'h00001 >= window) haw_o <= 1'b0;
			end
		end
	end

	// ********************************************************************
	// Synthetic pattern source
	// ********************************************************************

	// Wedges: horizontal follows the clock, vertical steps per line,
	// the dynamic one also advances once per frame.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wedge_q <= 8'h00;
			phase_q <= 8'h00;
		end else begin
			if (frame_i) phase_q <= phase_q + 8'h01;
			if (frame_i) wedge_q <= 8'h00;
			else if (line_i && !line_q) wedge_q <= wedge_q + 8'h01;
		end
	end

	// Source select; reserved codes output a blank, never-valid stream.
	always_comb begin
		vid_d = '0;
		case (src_q)
			afc_pkg::SRC_CAM: vid_d = cam_i;
			afc_pkg::SRC_CAM_NOVAL: vid_d = '{valid: line_i, taps: cam_i.taps};
			afc_pkg::SRC_HWEDGE: vid_d = '{valid: haw_o, taps: {afc_pkg::TAPS{hcnt_q[7:0]}}};
			afc_pkg::SRC_DWEDGE: vid_d = '{valid: haw_o, taps: {afc_pkg::TAPS{hcnt_q[7:0] + phase_q}}};
			afc_pkg::SRC_K00: vid_d = '{valid: haw_o, taps: {afc_pkg::TAPS{8'h00}}};
			afc_pkg::SRC_KFF: vid_d = '{valid: haw_o, taps: {afc_pkg::TAPS{8'hff}}};
			afc_pkg::SRC_KAA: vid_d = '{valid: haw_o, taps: {afc_pkg::TAPS{8'haa}}};
			afc_pkg::SRC_K55: vid_d = '{valid: haw_o, taps: {afc_pkg::TAPS{8'h55}}};
			afc_pkg::SRC_SEQ: vid_d = '{valid: haw_o, taps: afc_pkg::SEQ_BYTES};
			afc_pkg::SRC_VWEDGE: vid_d = '{valid: haw_o, taps: {afc_pkg::TAPS{wedge_q}}};
			default: vid_d = '0;
		endcase
	end

	// Force mode keeps each pixel's 8 low bits; for wider depths the taps
	// carry consecutive bytes, so only even bytes of each pixel survive.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			video_o <= '0;
		end else begin
			video_o.valid <= vid_d.valid;
			video_o.taps  <= vid_d.taps;
			if (force_q && full_bits > 5'd8) begin
				for (int i = 1; i < afc_pkg::TAPS; i += 2) video_o.taps[i*8 +: 8] <= 8'h00;
			end
		end
	end

	// ********************************************************************
	// Mode decode
	// ********************************************************************
	always_comb begin
		mode_d = '0;
		mode_d.window_clocks = window;
		mode_d.pack = afc_pkg::PK_MONO;
		case (dep_q)
			5'd0: mode_d.pix_bits = 5'd8;
			5'd1: mode_d.pix_bits = 5'd10;
			5'd2: mode_d.pix_bits = 5'd12;
			5'd3: mode_d.pix_bits = 5'd14;
			5'd4: mode_d.pix_bits = 5'd16;
			5'd9: mode_d.pix_bits = 5'd31;
			5'd10: mode_d.pix_bits = 5'd31;
			5'd5, 5'd11: begin
				mode_d.pix_bits = 5'd8;
				mode_d.pack = afc_pkg::PK_C32;
			end
			5'd6, 5'd12: begin
				mode_d.pix_bits = 5'd8;
				mode_d.pack = afc_pkg::PK_C24;
			end
			5'd7, 5'd13: begin
				mode_d.pix_bits = 5'd10;
				mode_d.pack = afc_pkg::PK_C10_32;
			end
			5'd8, 5'd14: begin
				mode_d.pix_bits = 5'd12;
				mode_d.pack = afc_pkg::PK_C12_48;
			end
			default: mode_d.pack = afc_pkg::PK_RSVD;
		endcase
		// The unforced depth is kept apart, since force hides it in pix_bits.
		full_bits = mode_d.pix_bits;
		if (force_q) mode_d.pix_bits = 5'd8;
		mode_d.bayer = (FORMAT_CODE == 5'd14) || (FORMAT_CODE == 5'd15) ||
			(FORMAT_CODE == 5'd16) || (FORMAT_CODE == 5'd21);
		mode_d.dual_cam = (FORMAT_CODE >= 5'd8) && (FORMAT_CODE <= 5'd12);
		mode_d.fmt_valid = (FORMAT_CODE <= 5'd24);
	end

	// Registered mode and ownership outputs.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_o     <= '0;
			uart_own_o <= 1'b0;
		end else begin
			mode_o     <= mode_d;
			uart_own_o <= own_q;
		end
	end

endmodule

// ==== verification/afc_cam_model.sv ====
// Camera model that plays one framed line of multi-tap video per call.
// Assumes the bench calls run_line and shares the design clock.
module afc_cam_model (
	input  wire logic              clk_i,   // Clock.
	input  wire logic              noval_i, // Camera never raises valid.
	output afc_pkg::afc_video_type cam_o,   // Taps and valid.
	output logic                   line_o,  // Line enable.
	output logic                   frame_o  // Frame start.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] pix;
	// Idle outputs at time zero.
	initial begin
		cam_o = '0;
		line_o = 1'b0;
		frame_o = 1'b0;
		pix = 64'h0706050403020100;
	end
	// ****
	// Line playback
	// ****
	// Eight pixels per clock; after the line the taps show the inverse of the
	// last word so stale data cannot pass for live video.
	task automatic run_line(input int n, input int gap);
		@(posedge clk_i);
		frame_o <= 1'b1;
		@(posedge clk_i);
		frame_o <= 1'b0;
		line_o <= 1'b1;
		repeat (n) begin
			cam_o <= {!noval_i, pix};
			pix = pix + 64'h0808080808080808;
			@(posedge clk_i);
		end
		line_o <= 1'b0;
		cam_o <= {1'b0, ~cam_o.taps};
		repeat (gap) @(posedge clk_i);
	endtask
endmodule

// ==== verification/afc_regs_props.sv ====
// Concurrent checks on the ports of the acquisition format register pair.
// Assumes one clock domain and a bind onto afc_regs.
// ****
// Checker
// ****
module afc_regs_props #(
	parameter logic [4:0] FORMAT_CODE = 5'h00 // Built-in format code.
) (
	input wire logic        clk_i,         // Clock.
	input wire logic        nrst_i,        // Reset, active low.
	input wire logic        wb_cyc_i,      // Cycle.
	input wire logic        wb_stb_i,      // Strobe.
	input wire logic        wb_we_i,       // Write.
	input wire logic [3:0]  wb_adr_i,      // Address.
	input wire logic [3:0]  wb_sel_i,      // Byte lanes.
	input wire logic [31:0] wb_dat_i,      // Write data.
	input wire logic [31:0] wb_dat_o,      // Read data.
	input wire logic        wb_ack_o,      // Acknowledge.
	input wire logic        line_i,        // Line enable.
	input wire logic        lane_a_we_i,   // Lane A request.
	input wire logic [14:0] lane_a_addr_i, // Lane A address.
	input wire logic        lane_b_we_i,   // Lane B request.
	input wire logic        lane_a_we_o,   // Lane A gated write.
	input wire logic        lane_b_we_o,   // Lane B gated write.
	input wire logic        haw_o,         // Window.
	input wire logic        uart_own_o     // Port ownership.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        take;
	logic        wp_q;
	logic        dbl_q;
	logic [14:0] la_q;
	logic [16:0] act_q;
	logic [17:0] hcnt_q;
	logic [17:0] win;
	assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign win = dbl_q ? {act_q, 1'b0} : {1'b0, act_q};
	// Shadow of the fields that shape the window and gate the buffer; reserved
	// multiplier codes count as x1.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp_q <= 1'b0;
			dbl_q <= 1'b0;
			act_q <= 17'h0;
		end else if (take) begin
			if (wb_adr_i == afc_pkg::ADDR_LANE_DIAG && wb_sel_i[1]) wp_q <= wb_dat_i[15];
			if (wb_adr_i == afc_pkg::ADDR_LINE_MULT && wb_sel_i[0]) dbl_q <= wb_dat_i[1:0] == 2'h1;
			if (wb_adr_i == afc_pkg::ADDR_FORMAT_CTRL && wb_sel_i[0]) act_q[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i == afc_pkg::ADDR_FORMAT_CTRL && wb_sel_i[1]) act_q[15:8] <= wb_dat_i[15:8];
			if (wb_adr_i == afc_pkg::ADDR_FORMAT_CTRL && wb_sel_i[2]) act_q[16] <= wb_dat_i[16];
		end
	end
	// Last lane A address and the length of the current window run.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			la_q <= 15'h0;
			hcnt_q <= 18'h0;
		end else begin
			if (lane_a_we_i && !wp_q) la_q <= lane_a_addr_i;
			hcnt_q <= haw_o ? hcnt_q + 18'h1 : 18'h0;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_fmt_ro;
		wb_ack_o && !wb_we_i && wb_adr_i == afc_pkg::ADDR_FORMAT_CTRL
			|-> wb_dat_o[21:17] == FORMAT_CODE;
	endproperty
	a_fmt_ro: assert property (p_fmt_ro) else $error("format field wrong");
	property p_lane_a;
		lane_a_we_i && !wp_q |=> lane_a_we_o;
	endproperty
	a_lane_a: assert property (p_lane_a) else $error("lane A write lost");
	property p_lane_b;
		lane_b_we_o |-> $past(lane_b_we_i) && !$past(wp_q);
	endproperty
	a_lane_b: assert property (p_lane_b) else $error("lane B write leaked");
	property p_lane_rd;
		wb_ack_o && !wb_we_i && wb_adr_i == afc_pkg::ADDR_LANE_DIAG
			|-> wb_dat_o[15:0] == {$past(wp_q), $past(la_q)};
	endproperty
	a_lane_rd: assert property (p_lane_rd) else $error("lane A readback");
	property p_own;
		take && wb_adr_i == afc_pkg::ADDR_LANE_DIAG && wb_sel_i[3]
			|-> ##2 uart_own_o == $past(wb_dat_i[31], 2);
	endproperty
	a_own: assert property (p_own) else $error("ownership bit");
	property p_haw_go;
		$rose(line_i) && !haw_o && win != 18'h0 |=> haw_o;
	endproperty
	a_haw_go: assert property (p_haw_go) else $error("window missing");
	property p_haw_len;
		$fell(haw_o) |-> hcnt_q == win;
	endproperty
	a_haw_len: assert property (p_haw_len) else $error("window length");
endmodule
bind afc_regs afc_regs_props #(.FORMAT_CODE(FORMAT_CODE)) i_props (
	.clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .line_i, .lane_a_we_i, .lane_a_addr_i, .lane_b_we_i,
	.lane_a_we_o, .lane_b_we_o, .haw_o, .uart_own_o
);

// ==== verification/tb.sv ====
// Self-checking bench for the acquisition format register pair.
// Assumes the design, the camera model and the checker bind compile first.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] FMT = 5'h0e; // One-tap Bayer build.
	logic                   clk, nrst, cyc, stb, we, ack, line, frame;
	logic                   awe, bwe, awo, bwo, haw, own, noval, m_wp, m_own;
	logic [3:0]             adr, sel;
	logic [1:0]             m_mult;
	logic [14:0]            aadr, badr, m_la, m_lb;
	logic [31:0]            wdat, rdat, rnd, m_ctrl;
	afc_pkg::afc_video_type cam, video;
	afc_pkg::afc_mode_type  mode;
	int                     failures, num_checks;
	afc_regs #(.FORMAT_CODE(FMT)) i_dut (
		.clk_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cam_i(cam), .line_i(line), .frame_i(frame), .lane_a_we_i(awe),
		.lane_a_addr_i(aadr), .lane_b_we_i(bwe), .lane_b_addr_i(badr), .video_o(video),
		.haw_o(haw), .lane_a_we_o(awo), .lane_b_we_o(bwo), .mode_o(mode), .uart_own_o(own)
	);
	afc_cam_model i_cam (.clk_i(clk), .noval_i(noval), .cam_o(cam), .line_o(line),
		.frame_o(frame));
	// Free-running 50 ns clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ****
	// Checking and bus helpers
	// ****
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic afc_pkg::afc_pack_type pk(input int d);
		case (d)
			0, 1, 2, 3, 4, 9, 10: return afc_pkg::PK_MONO;
			5, 11: return afc_pkg::PK_C32;
			6, 12: return afc_pkg::PK_C24;
			7, 13: return afc_pkg::PK_C10_32;
			8, 14: return afc_pkg::PK_C12_48;
			default: return afc_pkg::PK_RSVD;
		endcase
	endfunction
	// Wedges only promise equal taps, so they are judged against their own low byte.
	function automatic logic [63:0] vid_exp(input logic [63:0] t, input logic [63:0] v);
		case (m_ctrl[25:22])
			4'h0, 4'h1: return (m_ctrl[31] && m_ctrl[30:26] inside
				{[5'd1:5'd4], [5'd7:5'd10], 5'd13, 5'd14}) ? t & 64'h00ff00ff00ff00ff : t;
			4'h5: return 64'h0;
			4'h6: return {8{8'hff}};
			4'h7: return {8{8'haa}};
			4'h8: return {8{8'h55}};
			4'h9: return afc_pkg::SEQ_BYTES;
			default: return {8{v[7:0]}};
		endcase
	endfunction
	// One classic cycle; the request stands until ack is seen at a rising edge.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= d;
		do @(posedge clk);
		while (ack !== 1'b1);
		q = rdat;
		chk(ack, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		if (a == afc_pkg::ADDR_FORMAT_CTRL) m_ctrl = {d[31:22], FMT, d[16:0]};
		if (a == afc_pkg::ADDR_LANE_DIAG) {m_own, m_wp} = {d[31], d[15]};
		if (a == afc_pkg::ADDR_LINE_MULT) m_mult = d[1:0];
	endtask
	task automatic rd(input logic [3:0] a);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		case (a)
			afc_pkg::ADDR_FORMAT_CTRL: chk(q, m_ctrl);
			afc_pkg::ADDR_LANE_DIAG: chk(q, {m_own, m_lb, m_wp, m_la});
			afc_pkg::ADDR_LINE_MULT: chk(q, {30'h0, m_mult});
			default: chk(q, 32'h0);
		endcase
	endtask
	// Both lanes write at once; the gate answers one cycle later.
	task automatic lane(input logic [14:0] a, input logic [14:0] b);
		@(posedge clk);
		{awe, bwe, aadr, badr} <= {2'b11, a, b};
		@(posedge clk);
		{awe, bwe} <= 2'b00;
		#1;
		chk({awo, bwo}, {2{!m_wp}});
		if (!m_wp) {m_la, m_lb} = {a, b};
	endtask
	// Configure, play one line and compare window, valid count and every valid word.
	task automatic line_test(input logic [3:0] s, input logic [4:0] d, input logic f,
		input logic [16:0] w, input logic [1:0] m, input logic nv, input int ev);
		logic [63:0] c;
		int nh, nvd, ew;
		nh = 0;
		nvd = 0;
		noval <= nv;
		wr(afc_pkg::ADDR_LINE_MULT, {30'h0, m});
		wr(afc_pkg::ADDR_FORMAT_CTRL, {f, d, s, 5'h0, w});
		ew = m == 2'h1 ? 2 * w : w;
		repeat (2) @(posedge clk);
		chk(mode.window_clocks, ew);
		if (f) chk(mode.pix_bits, 8);
		fork
			i_cam.run_line(24, 4);
			repeat (40) begin
				@(posedge clk);
				c = cam.taps;
				#1;
				nh += haw;
				nvd += video.valid;
				if (video.valid === 1'b1) chk(video.taps, vid_exp(c, video.taps));
			end
		join
		chk(nh, ew);
		chk(nvd, ev);
		$display("test source %0d done", s);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****
	// Test sequence
	// ****
	initial begin
		{cyc, stb, we, awe, bwe, noval, adr, sel, wdat, aadr, badr} = '0;
		{m_mult, m_la, m_lb, m_wp, m_own, failures, num_checks} = '0;
		m_ctrl = {10'h0, FMT, 17'h0};
		rnd = 32'h13627c12;
		nrst = 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 0; a < 16; a += 4) rd(a[3:0]);
		wr(4'hc, 32'hffffffff);
		rd(4'hc);
		chk({mode.bayer, mode.dual_cam, mode.fmt_valid}, 3'b101);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			wr(afc_pkg::ADDR_FORMAT_CTRL, rnd);
			rd(afc_pkg::ADDR_FORMAT_CTRL);
			rnd = lfsr(rnd);
			wr(afc_pkg::ADDR_LANE_DIAG, rnd);
			@(posedge clk);
			chk(own, m_own);
			lane(rnd[14:0], rnd[30:16]);
			rd(afc_pkg::ADDR_LANE_DIAG);
			wr(afc_pkg::ADDR_LINE_MULT, {rnd[7:0], rnd[31:8]});
			rd(afc_pkg::ADDR_LINE_MULT);
		end
		$display("test random registers done");
		for (int d = 0; d < 17; d++) begin
			wr(afc_pkg::ADDR_FORMAT_CTRL, {1'b0, d[4:0], 26'h4});
			repeat (2) @(posedge clk);
			chk(mode.pack, pk(d));
			if (pk(d) == afc_pkg::PK_MONO) chk(mode.pix_bits, d < 5 ? 8 + 2 * d : 31);
		end
		$display("test depth decode done");
		line_test(4'h0, 5'h0, 1'b0, 17'h5, 2'h0, 1'b0, 24);
		line_test(4'h0, 5'h1, 1'b1, 17'h7, 2'h1, 1'b0, 24);
		line_test(4'h1, 5'h0, 1'b0, 17'h0, 2'h0, 1'b1, 24);
		line_test(4'h2, 5'h0, 1'b0, 17'h3, 2'h0, 1'b0, 0);
		for (int s = 3; s < 11; s++)
			line_test(s[3:0], 5'h0, 1'b0, 17'(s), 2'(s % 3), 1'b0, s % 3 == 1 ? 2 * s : s);
		tally_and_finish();
	end
	// Cuts a hang short well after the expected run of about a thousand cycles.
	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
endmodule
